// File: design/ssp_pkg.sv
// Shared constants and types for the two-wire sensor client port
package ssp_pkg;

  // Device clock and bus timing figures
  localparam longint unsigned CLK_HZ        = 64'd125_000_000;
  localparam longint unsigned POWERUP_MS    = 64'd15;
  localparam longint unsigned TIMEOUT_MS    = 64'd30;
  localparam int              POWERUP_CYC   = int'((POWERUP_MS * CLK_HZ) / 64'd1000);
  localparam int              TIMEOUT_CYC   = int'((TIMEOUT_MS * CLK_HZ) / 64'd1000);

  // Bus framing
  localparam int              BYTE_BITS     = 8;
  localparam logic [6:0]      ARA_ADDR      = 7'h0c;  // 0001_100
  localparam logic [6:0]      FIXED_ADDR    = 7'h4c;  // 1001_100

  // Address patterns selected by the decoded pull-up range, 4.7k up to 33k
  localparam int              RANGE_COUNT   = 6;
  localparam logic [6:0]      ADDR_TABLE [RANGE_COUNT] = '{
    7'h7c, 7'h5c, 7'h4c, 7'h6c, 7'h1c, 7'h3c
  };
  localparam logic [2:0]      RANGE_DEFAULT = 3'h2;

  // Reset values
  localparam logic [7:0]      PTR_RESET     = 8'h00;

  // Request towards the register file
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] index;
    logic [7:0] wdata;
  } ssp_reg_req_t;

  // Alert handshake with the status logic
  typedef struct packed {
    logic pending;
    logic mask_all;
  } ssp_alert_in_t;

endpackage

// File: design/ssp_addr_decode.sv
// Power-up address capture from the decoded pull-up range
`timescale 1ns/100ps
module ssp_addr_decode #(
  parameter int         POWERUP_CYCLES = ssp_pkg::POWERUP_CYC,
  parameter bit         SELECTABLE     = 1'b1,
  parameter logic [6:0] HARD_ADDR      = ssp_pkg::FIXED_ADDR
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [2:0] range_code,
  output logic      [6:0] own_addr,
  output logic            ready
);
  import ssp_pkg::*;

  localparam int CW = $clog2(POWERUP_CYCLES + 1);

  if (POWERUP_CYCLES < 1) begin : g_chk
    $error("POWERUP_CYCLES must be at least one");
  end

  typedef struct packed {
    logic [2:0]    meta;
    logic [2:0]    sync;
    logic [CW-1:0] count;
    logic          ready;
    logic [6:0]    addr;
  } ssp_dec_state_t;

  ssp_dec_state_t st;
  ssp_dec_state_t next_st;

  // Count out the quiet window, then latch the address once
  always_comb begin
    next_st      = st;
    next_st.meta = range_code;
    next_st.sync = st.meta;
    if (!st.ready) begin
      if (st.count == CW'(POWERUP_CYCLES - 1)) begin
        next_st.ready = 1'b1;
        if (!SELECTABLE) begin
          next_st.addr = HARD_ADDR;
        end else if (st.sync < 3'(RANGE_COUNT)) begin
          next_st.addr = ADDR_TABLE[st.sync];
        end else begin
          next_st.addr = ADDR_TABLE[RANGE_DEFAULT];
        end
      end else begin
        next_st.count = st.count + CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '{meta: 3'h0, sync: 3'h0, count: '0, ready: 1'b0, addr: 7'h00};
    end else begin
      st <= next_st;
    end
  end

  assign own_addr = st.addr;
  assign ready    = st.ready;

endmodule

// File: design/ssp_client.sv
// Two-wire bus client port of the temperature monitor
//
// Notes on behaviour
// - Ignore bus for 15ms after power-up
// - Data falls while clock high: start
// - First byte: 7-bit address, direction bit
// - Address chosen from decoded pull-up range
// - Bytes are eight bits, MSB first
// - Acknowledge address, index and first data byte
// - Data rises while clock high: stop, reset
// - Optional 30ms clock-low timeout resets protocol
// - Works from 10kHz to 400kHz
// - Wrong address or sequence: no ack, no change
// - Write byte: index, data, stored at stop
// - Read byte: index, repeated start, read
// - Index only then stop: pointer load
// - Short read returns pointed register
// - Alert response read returns own address
// - Full address sent, then set mask
// - Alert response leaves status flags alone
// - Mask set holds interrupt output released
`timescale 1ns/100ps
module ssp_client #(
  parameter int         POWERUP_CYCLES = ssp_pkg::POWERUP_CYC,
  parameter int         TIMEOUT_CYCLES = ssp_pkg::TIMEOUT_CYC,
  parameter bit         SELECTABLE     = 1'b1,
  parameter logic [6:0] HARD_ADDR      = ssp_pkg::FIXED_ADDR
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  bus_clock_pin_in,
  input  wire logic                  bus_data_pin_in,
  output logic                       bus_data_pin_out,
  output logic                       bus_data_pin_oe,
  output logic                       alert_pin_out,
  output logic                       alert_pin_oe,
  input  wire logic [2:0]            addr_range_code,
  input  wire logic                  timeout_enable,
  input  wire ssp_pkg::ssp_alert_in_t alert_in,
  output logic                       mask_set,
  output ssp_pkg::ssp_reg_req_t      reg_req,
  input  wire logic [7:0]            reg_rdata,
  output logic [6:0]                 own_addr,
  output logic                       addr_ready
);
  import ssp_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  if (TIMEOUT_CYCLES < 1) begin : g_chk
    $error("TIMEOUT_CYCLES must be at least one");
  end

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_RX_BYTE,
    S_RX_ACK,
    S_TX_BYTE,
    S_TX_ACK,
    S_IGNORE
  } ssp_fsm_t;

  typedef struct packed {
    logic          scl_meta;
    logic          scl_sync;
    logic          sda_meta;
    logic          sda_sync;
    logic          scl_prev;
    logic          sda_prev;
    ssp_fsm_t      fsm;
    logic [2:0]    bit_cnt;
    logic          byte_done;
    logic [7:0]    shift;
    logic          rw;
    logic          ara;
    logic [1:0]    byte_no;
    logic [7:0]    ptr;
    logic [7:0]    wdata;
    logic          wpend;
    logic          sda_oe;
    logic          reg_write;
    logic          reg_read;
    logic          mask_set;
    logic          alert_oe;
    logic [TW-1:0] tout;
  } ssp_state_t;

  ssp_state_t st;
  ssp_state_t next_st;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       tout_hit;
  logic       addr_hit;
  logic       ara_hit;
  logic [7:0] rx_byte;

  // Address capture at power-up
  ssp_addr_decode #(
    .POWERUP_CYCLES (POWERUP_CYCLES),
    .SELECTABLE     (SELECTABLE),
    .HARD_ADDR      (HARD_ADDR)
  ) u_decode (
    .clock      (clock),
    .reset      (reset),
    .range_code (addr_range_code),
    .own_addr   (own_addr),
    .ready      (addr_ready)
  );

  // Bus events from the synchronised lines only
  assign scl_rise   = st.scl_sync & ~st.scl_prev;
  assign scl_fall   = ~st.scl_sync & st.scl_prev;
  assign start_seen = st.scl_sync & st.scl_prev & st.sda_prev & ~st.sda_sync;
  assign stop_seen  = st.scl_sync & st.scl_prev & ~st.sda_prev & st.sda_sync;
  assign tout_hit   = timeout_enable && (st.tout == TW'(TIMEOUT_CYCLES));
  assign rx_byte    = st.shift;
  assign addr_hit   = (rx_byte[7:1] == own_addr);
  assign ara_hit    = (rx_byte[7:1] == ARA_ADDR) && rx_byte[0] &&
                      alert_in.pending && !alert_in.mask_all;

  // Next-state logic
  always_comb begin
    next_st           = st;
    // Both lines pass two flip-flops before any event logic
    next_st.scl_meta  = bus_clock_pin_in;
    next_st.scl_sync  = st.scl_meta;
    next_st.sda_meta  = bus_data_pin_in;
    next_st.sda_sync  = st.sda_meta;
    next_st.scl_prev  = st.scl_sync;
    next_st.sda_prev  = st.sda_sync;
    next_st.reg_write = 1'b0;
    next_st.reg_read  = 1'b0;
    next_st.mask_set  = 1'b0;
    // Interrupt output gated by the global mask
    next_st.alert_oe  = alert_in.pending & ~alert_in.mask_all;

    // Clock-low timer, cleared whenever the clock is high
    if (st.scl_sync || st.fsm == S_IDLE) begin
      next_st.tout = '0;
    end else if (st.tout != TW'(TIMEOUT_CYCLES)) begin
      next_st.tout = st.tout + TW'(1);
    end

    if (!addr_ready) begin
      // Quiet window after power-up
      next_st.fsm    = S_IDLE;
      next_st.sda_oe = 1'b0;
    end else if (stop_seen) begin
      // Commit a complete write, then wait for a new start
      // The stop's own clock rise shifts in one low bit
      if (st.wpend && st.fsm == S_RX_BYTE && !st.byte_done &&
          st.bit_cnt <= 3'h1) begin
        next_st.reg_write = 1'b1;
      end
      next_st.wpend  = 1'b0;
      next_st.fsm    = S_IDLE;
      next_st.sda_oe = 1'b0;
    end else if (start_seen) begin
      // New or repeated start drops any unfinished write
      next_st.fsm       = S_ADDR;
      next_st.bit_cnt   = 3'h0;
      next_st.byte_done = 1'b0;
      next_st.wpend     = 1'b0;
      next_st.sda_oe    = 1'b0;
    end else if (tout_hit) begin
      next_st.fsm    = S_IDLE;
      next_st.wpend  = 1'b0;
      next_st.sda_oe = 1'b0;
    end else begin
      // Every code of the state type is a state
      unique case (st.fsm)
        // Wait for the next start
        S_IDLE, S_IGNORE: begin
          next_st.sda_oe = 1'b0;
        end

        // Address byte, sampled on rising clock
        S_ADDR: begin
          if (scl_rise) begin
            next_st.shift   = {st.shift[6:0], st.sda_sync};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == 3'(BYTE_BITS - 1)) begin
              next_st.byte_done = 1'b1;
            end
          end else if (scl_fall && st.byte_done) begin
            next_st.byte_done = 1'b0;
            next_st.rw        = rx_byte[0];
            next_st.byte_no   = 2'h0;
            if (ara_hit) begin
              next_st.ara    = 1'b1;
              next_st.sda_oe = 1'b1;
              next_st.fsm    = S_ADDR_ACK;
            end else if (addr_hit) begin
              next_st.ara    = 1'b0;
              next_st.sda_oe = 1'b1;
              next_st.fsm    = S_ADDR_ACK;
            end else begin
              next_st.fsm    = S_IGNORE;
            end
          end
        end

        // Hold the acknowledge for one clock period
        S_ADDR_ACK: begin
          if (scl_fall) begin
            next_st.bit_cnt = 3'h0;
            if (st.rw) begin
              if (st.ara) begin
                next_st.shift = {own_addr, 1'b0};
              end else begin
                next_st.shift    = reg_rdata;
                next_st.reg_read = 1'b1;
              end
              next_st.sda_oe = st.ara ? ~own_addr[6] : ~reg_rdata[7];
              next_st.fsm    = S_TX_BYTE;
            end else begin
              next_st.sda_oe = 1'b0;
              next_st.fsm    = S_RX_BYTE;
            end
          end
        end

        // Index or data byte from the host
        S_RX_BYTE: begin
          if (scl_rise) begin
            next_st.shift   = {st.shift[6:0], st.sda_sync};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == 3'(BYTE_BITS - 1)) begin
              next_st.byte_done = 1'b1;
            end
          end else if (scl_fall && st.byte_done) begin
            next_st.byte_done = 1'b0;
            if (st.byte_no == 2'h0) begin
              next_st.ptr     = rx_byte;
              next_st.byte_no = 2'h1;
              next_st.sda_oe  = 1'b1;
              next_st.fsm     = S_RX_ACK;
            end else if (st.byte_no == 2'h1) begin
              next_st.wdata   = rx_byte;
              next_st.wpend   = 1'b1;
              next_st.byte_no = 2'h2;
              next_st.sda_oe  = 1'b1;
              next_st.fsm     = S_RX_ACK;
            end else begin
              next_st.wpend   = 1'b0;
              next_st.fsm     = S_IGNORE;
            end
          end
        end

        // Release the acknowledge at the next fall
        S_RX_ACK: begin
          if (scl_fall) begin
            next_st.sda_oe  = 1'b0;
            next_st.bit_cnt = 3'h0;
            next_st.fsm     = S_RX_BYTE;
          end
        end

        // Send a byte, checking the line on every bit
        S_TX_BYTE: begin
          if (scl_rise) begin
            if (st.shift[7] && !st.sda_sync) begin
              next_st.sda_oe = 1'b0;
              next_st.fsm    = S_IGNORE;
            end else begin
              next_st.bit_cnt = st.bit_cnt + 3'h1;
              if (st.bit_cnt == 3'(BYTE_BITS - 1)) begin
                next_st.byte_done = 1'b1;
                next_st.mask_set  = st.ara;
              end
            end
          end else if (scl_fall) begin
            if (st.byte_done) begin
              next_st.byte_done = 1'b0;
              next_st.sda_oe    = 1'b0;
              next_st.fsm       = S_TX_ACK;
            end else begin
              next_st.shift  = {st.shift[6:0], 1'b0};
              next_st.sda_oe = ~st.shift[6];
            end
          end
        end

        // Host answers: low asks for more, high ends the read
        S_TX_ACK: begin
          if (scl_rise) begin
            if (st.sda_sync) begin
              next_st.fsm = S_IGNORE;
            end else begin
              next_st.byte_done = 1'b1;
            end
          end else if (scl_fall && st.byte_done) begin
            next_st.byte_done = 1'b0;
            next_st.bit_cnt   = 3'h0;
            next_st.shift     = st.ara ? {own_addr, 1'b0} : reg_rdata;
            next_st.reg_read  = ~st.ara;
            next_st.sda_oe    = st.ara ? ~own_addr[6] : ~reg_rdata[7];
            next_st.fsm       = S_TX_BYTE;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '{
        scl_meta:  1'b1, scl_sync: 1'b1, sda_meta: 1'b1, sda_sync: 1'b1,
        scl_prev:  1'b1, sda_prev: 1'b1, fsm: S_IDLE, bit_cnt: 3'h0,
        byte_done: 1'b0, shift: 8'h00, rw: 1'b0, ara: 1'b0, byte_no: 2'h0,
        ptr:       PTR_RESET, wdata: 8'h00, wpend: 1'b0, sda_oe: 1'b0,
        reg_write: 1'b0, reg_read: 1'b0, mask_set: 1'b0, alert_oe: 1'b0,
        tout:      '0
      };
    end else begin
      st <= next_st;
    end
  end

  // Open-drain pins only ever pull low
  assign bus_data_pin_out = 1'b0;
  assign bus_data_pin_oe  = st.sda_oe;
  assign alert_pin_out    = 1'b0;
  assign alert_pin_oe     = st.alert_oe;
  assign mask_set         = st.mask_set;
  assign reg_req.write    = st.reg_write;
  assign reg_req.read     = st.reg_read;
  assign reg_req.index    = st.ptr;
  assign reg_req.wdata    = st.wdata;

endmodule

// File: testbench/ssp_client_asserts.sv
// Concurrent checks on the two-wire client port
`timescale 1ns/100ps
module ssp_client_asserts #(
  parameter int POWERUP_CYCLES = 50,
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic                   clock,
  input wire logic                   reset,
  input wire logic                   bus_clock_pin_in,
  input wire logic                   bus_data_pin_in,
  input wire logic                   bus_data_pin_oe,
  input wire logic                   alert_pin_oe,
  input wire logic                   timeout_enable,
  input wire ssp_pkg::ssp_alert_in_t alert_in,
  input wire logic                   mask_set,
  input wire ssp_pkg::ssp_reg_req_t  reg_req,
  input wire logic [6:0]             own_addr,
  input wire logic                   addr_ready
);
  import ssp_pkg::*;
  int up_cnt;
  int low_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Cycles since release and enabled clock-low run
  always_ff @(posedge clock) begin
    if (reset) up_cnt <= 0;
    else if (up_cnt < POWERUP_CYCLES + 4) up_cnt <= up_cnt + 1;
    if (reset || bus_clock_pin_in || !timeout_enable) low_cnt <= 0;
    else if (low_cnt < TIMEOUT_CYCLES + 9) low_cnt <= low_cnt + 1;
  end
  sequence drive_at_rise;
    $rose(bus_clock_pin_in) && bus_data_pin_oe;
  endsequence
  sequence stop_on_wire;
    bus_clock_pin_in && bus_data_pin_in && !bus_data_pin_oe;
  endsequence
  quiet_early_a: assert property (!addr_ready |-> !bus_data_pin_oe && !reg_req.write)
    else $error("bus activity before address ready");
  ready_time_a: assert property ($rose(addr_ready) |->
    up_cnt >= POWERUP_CYCLES - 1 && up_cnt <= POWERUP_CYCLES + 1)
    else $error("address ready at wrong time");
  addr_form_a: assert property (addr_ready && $past(addr_ready) |->
    own_addr[3:0] == 4'hc && $stable(own_addr))
    else $error("bad or moving own address");
  alert_level_a: assert property (!$past(reset) |->
    alert_pin_oe == $past(alert_in.pending && !alert_in.mask_all))
    else $error("interrupt pin does not follow pending and mask");
  ara_mask_a: assert property (mask_set |-> alert_pin_oe ##1 !mask_set)
    else $error("mask set pulse wrong");
  ack_low_a: assert property ($rose(bus_data_pin_oe) |-> !bus_clock_pin_in)
    else $error("data driven while clock high");
  hold_high_a: assert property (drive_at_rise |=> bus_data_pin_oe [*3])
    else $error("data drive dropped while clock high");
  write_stop_a: assert property (reg_req.write |-> stop_on_wire ##1 !reg_req.write)
    else $error("write not at stop");
  timeout_a: assert property (low_cnt == TIMEOUT_CYCLES + 8 |-> !bus_data_pin_oe)
    else $error("no release after clock low timeout");
endmodule

bind ssp_client ssp_client_asserts #(
  .POWERUP_CYCLES(POWERUP_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_asserts (
  .clock(clock), .reset(reset), .bus_clock_pin_in(bus_clock_pin_in),
  .bus_data_pin_in(bus_data_pin_in), .bus_data_pin_oe(bus_data_pin_oe),
  .alert_pin_oe(alert_pin_oe), .timeout_enable(timeout_enable), .alert_in(alert_in),
  .mask_set(mask_set), .reg_req(reg_req), .own_addr(own_addr), .addr_ready(addr_ready)
);

// File: testbench/ssp_host_model.sv
// Bus host model driving clock and data of the two-wire link
`timescale 1ns/100ps
module ssp_host_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  int stretch = 0;
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // One bit slot, sampled at the clock rise
  task automatic bit_x(input logic b, output logic r);
    #16 sda_pull = ~b;
    #(32 + stretch) scl = 1'b1;
    r = sda;
    #32 scl = 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    if (!scl) begin
      #16 sda_pull = 1'b0;
      #32 scl = 1'b1;
    end
    #32 sda_pull = 1'b1;
    #32 scl = 1'b0;
  endtask
  // Stop, then bus free time
  task automatic stop();
    #16 sda_pull = 1'b1;
    #32 scl = 1'b1;
    #32 sda_pull = 1'b0;
    #80;
  endtask
  // Byte out, most significant bit first
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Byte in, closed by not-acknowledge
  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(1'b1, r);
  endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the two-wire client port
`timescale 1ns/100ps
module testbench;
  import ssp_pkg::*;
  localparam int PU = 50;
  localparam int TO = 200;
  logic          clock = 1'b0;
  logic          reset = 1'b1;
  logic          tmo_en = 1'b0;
  logic [2:0]    range = 3'h0;
  ssp_alert_in_t alert = '0;
  logic          mask_set, oe, aoe, scl, pull, ready, dout, aout;
  int            reads = 0;
  ssp_reg_req_t  req;
  logic [6:0]    own, me;
  logic [7:0]    regs [256];
  logic [7:0]    model [256];
  logic [15:0]   wr_q [$];
  int            fails = 0;
  int            compares = 0;
  int            cycles = 0;
  wire           sda = ~(pull | oe);
  wire [7:0]     rdata = regs[req.index];

  ssp_client #(.POWERUP_CYCLES(PU), .TIMEOUT_CYCLES(TO)) DUT (
    .clock(clock), .reset(reset), .bus_clock_pin_in(scl), .bus_data_pin_in(sda),
    .bus_data_pin_out(dout), .bus_data_pin_oe(oe), .alert_pin_out(aout), .alert_pin_oe(aoe),
    .addr_range_code(range), .timeout_enable(tmo_en), .alert_in(alert),
    .mask_set(mask_set), .reg_req(req), .reg_rdata(rdata), .own_addr(own),
    .addr_ready(ready));
  ssp_host_model host (.scl(scl), .sda_pull(pull), .sda(sda));

  // Device clock
  initial begin
    forever #4 clock = ~clock;
  end

  // Register file, mask bit and cycle limit
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (req.write) begin
      regs[req.index] <= req.wdata;
      wr_q.push_back({req.index, req.wdata});
    end
    if (mask_set) alert.mask_all <= 1'b1;
    if (req.read) reads <= reads + 1;
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Write transfer of n bytes after the address
  task automatic wr(input logic [6:0] a, input int n, input logic [23:0] b,
                    output logic [3:0] ak);
    @(posedge clock);
    #0.5;
    ak = '0;
    host.start();
    host.send({a, 1'b0}, ak[3]);
    for (int i = 0; i < n; i++) host.send(b[23-8*i -: 8], ak[2-i]);
    host.stop();
  endtask

  // Short read transfer
  task automatic rd(input logic [6:0] a, output logic ak, output logic [7:0] d);
    @(posedge clock);
    #0.5;
    host.start();
    host.send({a, 1'b1}, ak);
    host.recv(d);
    host.stop();
  endtask

  // Main sequence
  initial begin
    logic [7:0] idx, d, d2, aw;
    logic [3:0] ak;
    logic       a1;
    int         n0;
    void'($urandom(27));
    foreach (regs[i]) begin
      regs[i] = 8'($urandom);
      model[i] = regs[i];
    end
    repeat (4) @(posedge clock);
    range <= 3'($urandom % 6);
    reset <= 1'b0;
    repeat (PU + 10) @(posedge clock);
    #1;
    me = ADDR_TABLE[range];
    check(ready, 1'b1);
    check(own, me);
    check({dout, aout}, 2'b00);
    $display("test 1 done");
    idx = 8'($urandom);
    d = 8'($urandom);
    wr(me, 2, {idx, d, 8'h00}, ak);
    check(ak, 4'he);
    check(wr_q.size(), 1);
    check(wr_q.pop_front(), {idx, d});
    model[idx] = d;
    $display("test 2 done");
    host.stretch = $urandom % 200;
    @(posedge clock);
    #0.5;
    host.start();
    host.send({me, 1'b0}, ak[3]);
    host.send(idx, ak[2]);
    host.start();
    host.send({me, 1'b1}, ak[1]);
    host.recv(d2);
    host.stop();
    host.stretch = 0;
    check(ak[3:1], 3'h7);
    check(d2, model[idx]);
    $display("test 3 done");
    d = 8'($urandom);
    wr(me, 1, {d, 16'h0000}, ak);
    check(ak[3:2], 2'h3);
    check(wr_q.size(), 0);
    n0 = reads;
    repeat (2) begin
      rd(me, a1, d2);
      check({a1, d2}, {1'b1, model[d]});
    end
    check(reads - n0, 2);
    $display("test 4 done");
    wr(me ^ 7'h01, 2, {idx, ~d, 8'h00}, ak);
    check(ak, 4'h0);
    wr(me, 3, {idx, ~d, d}, ak);
    check(ak, 4'he);
    check(wr_q.size(), 0);
    rd(me, a1, d2);
    check(d2, model[idx]);
    $display("test 5 done");
    @(posedge clock);
    alert.pending <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check(aoe, 1'b1);
    rd(ARA_ADDR, a1, d2);
    check({a1, d2}, {1'b1, me, 1'b0});
    check({alert.mask_all, aoe}, 2'b10);
    @(posedge clock);
    alert.mask_all <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(aoe, 1'b1);
    @(posedge clock);
    alert.pending <= 1'b0;
    rd(ARA_ADDR, a1, d2);
    check(a1, 1'b0);
    $display("test 6 done");
    // Host pulls the first released bit low: the device must give up
    wr(me, 2, {idx, 8'h80, 8'h00}, ak);
    check(wr_q.pop_front(), {idx, 8'h80});
    model[idx] = 8'h80;
    @(posedge clock);
    #0.5;
    host.start();
    host.send({me, 1'b1}, a1);
    host.bit_x(1'b0, d2[7]);
    for (int i = 6; i >= 0; i--) host.bit_x(1'b1, d2[i]);
    host.bit_x(1'b1, a1);
    host.stop();
    check(d2, 8'h7f);
    $display("test 7 done");
    // Clock held low while the address acknowledge stands
    aw = {me, 1'b0};
    @(posedge clock);
    #0.5;
    host.start();
    for (int i = 7; i >= 0; i--) host.bit_x(aw[i], a1);
    #(TO * 16);
    check(oe, 1'b1);
    @(posedge clock);
    tmo_en <= 1'b1;
    #(TO * 16 + 1);
    check(oe, 1'b0);
    host.stop();
    rd(me, a1, d2);
    check({a1, d2}, {1'b1, model[idx]});
    $display("test 8 done");
    print_verdict();
  end
endmodule
